// *** include/usds_pkg.sv ***
package usds_pkg;

  // Register offsets
  localparam logic [3:0] ADDR_IR0    = 4'h0;
  localparam logic [3:0] ADDR_IR1    = 4'h1;
  localparam logic [3:0] ADDR_IR2    = 4'h2;
  localparam logic [3:0] ADDR_IR3    = 4'h3;
  localparam logic [3:0] ADDR_OR0    = 4'h4;
  localparam logic [3:0] ADDR_OR1    = 4'h5;
  localparam logic [3:0] ADDR_OR2    = 4'h6;
  localparam logic [3:0] ADDR_OR3    = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // Input report byte 0 fields
  localparam int IR0_VOL_UP_BIT   = 0;
  localparam int IR0_VOL_DOWN_BIT = 1;
  localparam int IR0_PMUTE_BIT    = 2;

  // Status register fields
  localparam int ST_SPEAKER_BIT = 0;
  localparam int ST_MIXER_BIT   = 1;
  localparam int ST_SELFPW_BIT  = 2;
  localparam int ST_EEOK_BIT    = 3;
  localparam int ST_READY_BIT   = 4;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // EEPROM option word
  localparam logic [11:0] EE_SIGNATURE   = 12'h670;
  localparam int          EE_SERIAL_BIT  = 2;
  localparam int          EE_PRODUCT_BIT = 1;

  // Built-in identity, values arbitrary
  localparam logic [15:0] BUILTIN_VID      = 16'h1234;
  localparam logic [15:0] BUILTIN_PID_BASE = 16'h5670;

  // Strap settle count before latching
  localparam logic [2:0] LATCH_WAIT_CYCLES = 3'h4;

  // Configuration total lengths, plain defaults
  localparam logic [15:0] TOTLEN_SPEAKER   = 16'h0080;
  localparam logic [15:0] TOTLEN_HEADSET   = 16'h00E0;
  localparam logic [15:0] TOTLEN_HS_MIXER  = 16'h0100;

  // Descriptor constants
  localparam logic [7:0] CFG_LEN        = 8'h09;
  localparam logic [7:0] CFG_TYPE       = 8'h02;
  localparam logic [7:0] CFG_VALUE      = 8'h01;
  localparam logic [7:0] NUMIF_SPEAKER  = 8'h03;
  localparam logic [7:0] NUMIF_HEADSET  = 8'h04;
  localparam logic [7:0] ATTR_BUS       = 8'hA0;
  localparam logic [7:0] ATTR_SELF      = 8'hE0;
  localparam logic [7:0] MAXP_100MA     = 8'h32;
  localparam logic [7:0] MAXP_500MA     = 8'hFA;
  localparam logic [7:0] IF_LEN         = 8'h09;
  localparam logic [7:0] IF_TYPE        = 8'h04;
  localparam logic [7:0] HID_IF_NUM     = 8'h03;
  localparam logic [7:0] HID_NUM_EP     = 8'h01;
  localparam logic [7:0] HID_CLASS      = 8'h03;
  localparam logic [7:0] HIDC_LEN       = 8'h09;
  localparam logic [7:0] HIDC_TYPE      = 8'h21;
  localparam logic [15:0] HIDC_VERSION  = 16'h0100;
  localparam logic [7:0] HIDC_NUM_DESC  = 8'h01;
  localparam logic [7:0] REPORT_TYPE    = 8'h22;
  localparam logic [15:0] REPORT_LEN    = 16'h0030;
  localparam logic [7:0] EP_LEN         = 8'h07;
  localparam logic [7:0] EP_TYPE        = 8'h05;
  localparam logic [7:0] EP_ADDR        = 8'h83;
  localparam logic [7:0] EP_ATTR        = 8'h03;
  localparam logic [15:0] EP_MAXPKT     = 16'h0004;
  localparam logic [7:0] EP_INTERVAL    = 8'h20;

  typedef enum logic [1:0] {
    DSEL_CONFIG    = 2'b00,
    DSEL_HID_IF    = 2'b01,
    DSEL_HID_CLASS = 2'b10,
    DSEL_ENDPOINT  = 2'b11
  } usds_dsel_type;

  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_LATCH = 2'b01,
    ST_HOLD  = 2'b10
  } usds_state_type;

endpackage : usds_pkg

// *** core/usds_sync.sv ***
`timescale 1ns/1ps
module usds_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : usds_sync

// *** core/usds_descriptor_select.sv ***
`timescale 1ns/1ps
// How it works
// - Config descriptor 9 bytes, type 02, length varies
// - Three or four interfaces by mode
// - Attributes E0 only with mode and power straps high, else A0
// - Max power 32 with power strap high, else FA
// - Decode four mode and power combinations
// - Mode high selects playback-only speaker mode
// - Speaker ignores mixer; one IT, OT, FU
// - Mode low selects playback plus recording
// - Headset mixer adds mixer and feature unit
// - EEPROM option bit 2 enables serial string
// - EEPROM option bit 1 enables product string
// - HID interface descriptor fixed fields
// - HID class descriptor, version 0100, one subordinate
// - Report descriptor type 22, length 0030
// - Interrupt IN endpoint 83, interval 20
// - Report volume and mute buttons over HID
// - Host reads and writes internal registers
// - Mixer strap high adds muted mixer in headset mode only
// - Present EEPROM with signature 670 overrides VID, PID, serial
module usds_descriptor_select
  import usds_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Strap pins
  input  wire logic        mode_strap,
  input  wire logic        mixer_select_strap,
  input  wire logic        power_select_strap,
  // External EEPROM contents
  input  wire logic        eeprom_present,
  input  wire logic [15:0] eeprom_option,
  input  wire logic [15:0] eeprom_vendor_id,
  input  wire logic [15:0] eeprom_product_id,
  // Buttons, low when pressed
  input  wire logic        vol_up_n,
  input  wire logic        vol_down_n,
  input  wire logic        play_mute_n,
  // Descriptor request
  input  wire logic        desc_req,
  input  wire logic [1:0]  desc_sel,
  input  wire logic [3:0]  desc_offset,
  output logic      [7:0]  desc_data,
  output logic             desc_valid,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Selected configuration
  output logic             config_ready,
  output logic             speaker_mode,
  output logic             recording_en,
  output logic             mixer_present,
  output logic             mixer_default_mute,
  output logic             self_powered,
  output logic      [1:0]  topo_feature_units,
  output logic             topo_mixer_units,
  output logic      [15:0] vendor_id,
  output logic      [15:0] product_id,
  output logic             serial_override,
  output logic             serial_string_en,
  output logic             product_string_en,
  // HID reporting
  output logic             hid_report_pend,
  output logic      [31:0] hid_out_report
);

  logic [2:0]     strap_s;
  logic [48:0]    ee_s;
  logic [2:0]     btn_s;
  usds_state_type state_q;
  logic [2:0]     cnt_q;
  logic           ee_ok;
  logic           mute_prev_q;
  logic           mute_rel;
  logic [1:0]     vol_prev_q;
  logic           pmute_ev_q;
  logic [7:0]     ir0;
  logic [7:0]     or_q [4];
  logic           ir0_rd;
  logic           power_select_q;

  usds_sync #(.W(3)) u_strap_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     ({mode_strap, mixer_select_strap, power_select_strap}),
    .dout    (strap_s)
  );

  usds_sync #(.W(49)) u_ee_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     ({eeprom_present, eeprom_option, eeprom_vendor_id,
               eeprom_product_id}),
    .dout    (ee_s)
  );

  // Buttons reset to released, no false edge after reset
  usds_sync #(.W(3), .RST_VAL(3'h7)) u_btn_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     ({vol_up_n, vol_down_n, play_mute_n}),
    .dout    (btn_s)
  );

  function automatic logic [7:0] desc_byte(
    input logic [1:0] sel,
    input logic [3:0] off,
    input logic       spk,
    input logic       mix,
    input logic       selfp,
    input logic       p100
  );
    logic [15:0] tl;
    tl = spk ? TOTLEN_SPEAKER : (mix ? TOTLEN_HS_MIXER : TOTLEN_HEADSET);
    desc_byte = 8'h00;
    case (sel)
      DSEL_CONFIG: begin
        case (off)
          4'h0: desc_byte = CFG_LEN;
          4'h1: desc_byte = CFG_TYPE;
          4'h2: desc_byte = tl[7:0];
          4'h3: desc_byte = tl[15:8];
          4'h4: desc_byte = spk ? NUMIF_SPEAKER : NUMIF_HEADSET;
          4'h5: desc_byte = CFG_VALUE;
          4'h7: desc_byte = selfp ? ATTR_SELF : ATTR_BUS;
          4'h8: desc_byte = p100 ? MAXP_100MA : MAXP_500MA;
          default: desc_byte = 8'h00;
        endcase
      end
      DSEL_HID_IF: begin
        case (off)
          4'h0: desc_byte = IF_LEN;
          4'h1: desc_byte = IF_TYPE;
          4'h2: desc_byte = HID_IF_NUM;
          4'h4: desc_byte = HID_NUM_EP;
          4'h5: desc_byte = HID_CLASS;
          default: desc_byte = 8'h00;
        endcase
      end
      DSEL_HID_CLASS: begin
        case (off)
          4'h0: desc_byte = HIDC_LEN;
          4'h1: desc_byte = HIDC_TYPE;
          4'h2: desc_byte = HIDC_VERSION[7:0];
          4'h3: desc_byte = HIDC_VERSION[15:8];
          4'h5: desc_byte = HIDC_NUM_DESC;
          4'h6: desc_byte = REPORT_TYPE;
          4'h7: desc_byte = REPORT_LEN[7:0];
          4'h8: desc_byte = REPORT_LEN[15:8];
          default: desc_byte = 8'h00;
        endcase
      end
      default: begin
        case (off)
          4'h0: desc_byte = EP_LEN;
          4'h1: desc_byte = EP_TYPE;
          4'h2: desc_byte = EP_ADDR;
          4'h3: desc_byte = EP_ATTR;
          4'h4: desc_byte = EP_MAXPKT[7:0];
          4'h5: desc_byte = EP_MAXPKT[15:8];
          4'h6: desc_byte = EP_INTERVAL;
          default: desc_byte = 8'h00;
        endcase
      end
    endcase
  endfunction : desc_byte

  // Latch sequencing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_WAIT;
      cnt_q   <= 3'h0;
    end else begin
      case (state_q)
        ST_WAIT: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == LATCH_WAIT_CYCLES) begin
            state_q <= ST_LATCH;
          end
        end
        ST_LATCH: state_q <= ST_HOLD;
        ST_HOLD:  state_q <= ST_HOLD;
        default:  state_q <= ST_WAIT;
      endcase
    end
  end

  assign ee_ok = ee_s[48] && (ee_s[47:36] == EE_SIGNATURE);

  // Configuration capture, once per reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      config_ready       <= 1'b0;
      speaker_mode       <= 1'b0;
      recording_en       <= 1'b0;
      mixer_present      <= 1'b0;
      mixer_default_mute <= 1'b0;
      self_powered       <= 1'b0;
      topo_feature_units <= 2'h0;
      topo_mixer_units   <= 1'b0;
      vendor_id          <= 16'h0000;
      product_id         <= 16'h0000;
      serial_override    <= 1'b0;
      serial_string_en   <= 1'b0;
      product_string_en  <= 1'b0;
    end else if (state_q == ST_LATCH) begin
      config_ready       <= 1'b1;
      speaker_mode       <= strap_s[2];
      recording_en       <= !strap_s[2];
      mixer_present      <= !strap_s[2] && strap_s[1];
      mixer_default_mute <= !strap_s[2] && strap_s[1];
      self_powered       <= strap_s[2] && strap_s[0];
      topo_feature_units <= strap_s[2] ? 2'h1 :
                            (strap_s[1] ? 2'h3 : 2'h2);
      topo_mixer_units   <= !strap_s[2] && strap_s[1];
      vendor_id          <= ee_ok ? ee_s[31:16] : BUILTIN_VID;
      product_id         <= ee_ok ? ee_s[15:0] :
                            (BUILTIN_PID_BASE | {13'h0000, strap_s});
      serial_override    <= ee_ok;
      serial_string_en   <= ee_ok && ee_s[32+EE_SERIAL_BIT];
      product_string_en  <= !ee_ok || ee_s[32+EE_PRODUCT_BIT];
    end
  end

  // Descriptor answer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      desc_data  <= 8'h00;
      desc_valid <= 1'b0;
    end else begin
      desc_valid <= desc_req && config_ready;
      desc_data  <= (desc_req && config_ready) ?
                    desc_byte(desc_sel, desc_offset, speaker_mode,
                              mixer_present, self_powered,
                              power_select_q) : 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      power_select_q <= 1'b0;
    end else if (state_q == ST_LATCH) begin
      power_select_q <= strap_s[0];
    end
  end

  // Button reporting
  assign mute_rel = btn_s[0] && !mute_prev_q;
  assign ir0_rd   = reg_rd && (reg_addr == ADDR_IR0);
  assign ir0      = {5'h00, pmute_ev_q, !btn_s[1], !btn_s[2]};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mute_prev_q <= 1'b1;
      vol_prev_q  <= 2'h3;
    end else begin
      mute_prev_q <= btn_s[0];
      vol_prev_q  <= btn_s[2:1];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pmute_ev_q <= 1'b0;
    end else if (mute_rel) begin
      pmute_ev_q <= 1'b1;
    end else if (ir0_rd) begin
      pmute_ev_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hid_report_pend <= 1'b0;
    end else if (mute_rel || (btn_s[2:1] != vol_prev_q)) begin
      hid_report_pend <= 1'b1;
    end else if (ir0_rd) begin
      hid_report_pend <= 1'b0;
    end
  end

  // Output report registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        or_q[i] <= REG_RESET;
      end
    end else if (reg_wr && (reg_addr[3:2] == ADDR_OR0[3:2])) begin
      or_q[reg_addr[1:0]] <= reg_wdata;
    end
  end

  assign hid_out_report = {or_q[3], or_q[2], or_q[1], or_q[0]};

  // Read port
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_IR0:    reg_rdata <= ir0;
        ADDR_OR0, ADDR_OR1, ADDR_OR2, ADDR_OR3:
                     reg_rdata <= or_q[reg_addr[1:0]];
        ADDR_STATUS: reg_rdata <= {3'h0, config_ready, serial_override,
                                   self_powered, mixer_present,
                                   speaker_mode};
        default:     reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_cfg_head;
    desc_req && config_ready && desc_sel == DSEL_CONFIG &&
      desc_offset == 4'h1 |=> desc_valid && desc_data == CFG_TYPE;
  endproperty
  a_cfg_head: assert property (p_cfg_head)
    else $error("config type byte wrong");

  property p_numif;
    desc_req && config_ready && desc_sel == DSEL_CONFIG &&
      desc_offset == 4'h4 |=>
      desc_data == (speaker_mode ? NUMIF_SPEAKER : NUMIF_HEADSET);
  endproperty
  a_numif: assert property (p_numif)
    else $error("interface count wrong");

  property p_power;
    desc_req && config_ready && desc_sel == DSEL_CONFIG &&
      desc_offset == 4'h8 |=>
      desc_data == ($past(power_select_q) ? MAXP_100MA : MAXP_500MA);
  endproperty
  a_power: assert property (p_power)
    else $error("max power byte wrong");

  property p_attr;
    desc_req && config_ready && desc_sel == DSEL_CONFIG &&
      desc_offset == 4'h7 |=>
      desc_data == ((speaker_mode && power_select_q) ? ATTR_SELF : ATTR_BUS);
  endproperty
  a_attr: assert property (p_attr)
    else $error("attributes byte wrong");

  property p_speaker;
    config_ready && speaker_mode |->
      !recording_en && !mixer_present && topo_feature_units == 2'h1;
  endproperty
  a_speaker: assert property (p_speaker)
    else $error("speaker topology wrong");

  property p_headset;
    config_ready && !speaker_mode |-> recording_en &&
      topo_feature_units == (mixer_present ? 2'h3 : 2'h2);
  endproperty
  a_headset: assert property (p_headset)
    else $error("headset topology wrong");

  property p_ep_addr;
    desc_req && config_ready && desc_sel == DSEL_ENDPOINT &&
      desc_offset == 4'h2 |=> desc_data == EP_ADDR;
  endproperty
  a_ep_addr: assert property (p_ep_addr)
    else $error("endpoint address wrong");

  property p_report_len;
    desc_req && config_ready && desc_sel == DSEL_HID_CLASS &&
      desc_offset == 4'h7 |=> desc_data == REPORT_LEN[7:0];
  endproperty
  a_report_len: assert property (p_report_len)
    else $error("report length wrong");

  property p_hold;
    config_ready |=> config_ready && $stable(product_id) &&
      $stable(vendor_id) && $stable(speaker_mode);
  endproperty
  a_hold: assert property (p_hold)
    else $error("configuration changed after latch");

  property p_mute;
    mute_rel |=> pmute_ev_q && hid_report_pend;
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute release not reported");

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");

  property p_ready_time;
    $rose(state_q == ST_LATCH) |=> config_ready;
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("latch did not set ready");

  c_speaker: cover property (config_ready && speaker_mode);
  c_mixer:   cover property (config_ready && mixer_present);
  c_ee:      cover property (config_ready && serial_override);
  c_mute_rd: cover property (pmute_ev_q && ir0_rd);

endmodule : usds_descriptor_select

// *** bench/usds_host_model.sv ***
`timescale 1ns/1ps
module usds_host_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Descriptor port
  output logic            desc_req,
  output logic [1:0]      desc_sel,
  output logic [3:0]      desc_offset,
  input  wire logic [7:0] desc_data,
  input  wire logic       desc_valid
);
  initial begin
    desc_req    = 1'b0;
    desc_sel    = 2'h0;
    desc_offset = 4'h0;
  end

  // One byte request; answer taken at the edge after the request edge
  task automatic fetch(input logic [1:0] sel, input logic [3:0] off,
                       output logic [7:0] data, output logic vld);
    @(posedge ref_clk);
    desc_req    <= 1'b1;
    desc_sel    <= sel;
    desc_offset <= off;
    @(posedge ref_clk);
    desc_req <= 1'b0;
    @(posedge ref_clk);
    data = desc_data;
    vld  = desc_valid;
  endtask : fetch
endmodule : usds_host_model

// *** bench/test_usds_descriptor_select.sv ***
`timescale 1ns/1ps
module test_usds_descriptor_select
  import usds_pkg::*;
;
  logic        ref_clk, resetn, mode_strap, mixer_select_strap;
  logic        power_select_strap, eeprom_present;
  logic [15:0] eeprom_option, eeprom_vendor_id, eeprom_product_id;
  logic        vol_up_n, vol_down_n, play_mute_n, desc_req, desc_valid;
  logic [1:0]  desc_sel, topo_feature_units;
  logic [3:0]  desc_offset, reg_addr;
  logic [7:0]  desc_data, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, config_ready, speaker_mode, recording_en;
  logic        mixer_present, mixer_default_mute, self_powered;
  logic        topo_mixer_units, serial_override, serial_string_en;
  logic        product_string_en, hid_report_pend;
  logic [15:0] vendor_id, product_id;
  logic [31:0] hid_out_report;
  int          errors, checks;

  usds_descriptor_select dut (
    .ref_clk, .resetn, .mode_strap, .mixer_select_strap,
    .power_select_strap, .eeprom_present, .eeprom_option,
    .eeprom_vendor_id, .eeprom_product_id, .vol_up_n, .vol_down_n,
    .play_mute_n, .desc_req, .desc_sel, .desc_offset, .desc_data,
    .desc_valid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .config_ready, .speaker_mode, .recording_en, .mixer_present,
    .mixer_default_mute, .self_powered, .topo_feature_units,
    .topo_mixer_units, .vendor_id, .product_id, .serial_override,
    .serial_string_en, .product_string_en, .hid_report_pend,
    .hid_out_report
  );

  usds_host_model host (
    .ref_clk, .resetn, .desc_req, .desc_sel, .desc_offset, .desc_data,
    .desc_valid
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk_b(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask : chk_b

  task automatic chk_v(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_v

  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : reg_read

  task automatic do_reset(input logic [3:0] k);
    @(posedge ref_clk);
    resetn             <= 1'b0;
    mode_strap         <= k[0];
    power_select_strap <= k[1];
    mixer_select_strap <= k[2];
    eeprom_present     <= k[3];
    eeprom_option      <= {12'h670, 1'b0, k[2], k[1], 1'b0};
    eeprom_vendor_id   <= {12'hA50, k};
    eeprom_product_id  <= {12'hB60, k};
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask : do_reset

  function automatic logic [7:0] exp_desc(input logic [1:0] s,
      input logic [3:0] o, input logic spk, input logic pwr,
      input logic mix);
    logic [15:0] tl;
    logic [7:0]  t [0:8];
    tl = spk ? TOTLEN_SPEAKER : (mix ? TOTLEN_HS_MIXER : TOTLEN_HEADSET);
    case (s)
      2'h0: t = '{8'h09, 8'h02, tl[7:0], tl[15:8],
                  spk ? 8'h03 : 8'h04, 8'h01, 8'h00,
                  (spk & pwr) ? 8'hE0 : 8'hA0, pwr ? 8'h32 : 8'hFA};
      2'h1: t = '{8'h09, 8'h04, 8'h03, 8'h00, 8'h01, 8'h03, 8'h00,
                  8'h00, 8'h00};
      2'h2: t = '{8'h09, 8'h21, 8'h00, 8'h01, 8'h00, 8'h01, 8'h22,
                  8'h30, 8'h00};
      default: t = '{8'h07, 8'h05, 8'h83, 8'h03, 8'h04, 8'h00, 8'h20,
                     8'h00, 8'h00};
    endcase
    exp_desc = (o > 4'h8) ? 8'h00 : t[o];
  endfunction : exp_desc

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    results();
  end

  initial begin
    logic [7:0] d;
    logic       v, spk, pwr, mix, ee;
    int         n;
    errors = 0;
    checks = 0;
    resetn = 1'b0;
    {mode_strap, mixer_select_strap, power_select_strap} = 3'h0;
    eeprom_present = 1'b0;
    eeprom_option = 16'h0000;
    eeprom_vendor_id = 16'h0000;
    eeprom_product_id = 16'h0000;
    {vol_up_n, vol_down_n, play_mute_n} = 3'h7;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    for (int i = 0; i < 16; i++) begin
      {ee, mix, pwr, spk} = i[3:0];
      do_reset(i[3:0]);
      host.fetch(2'h1, 4'h0, d, v);
      chk_b("early desc_valid", 1'b0, v);
      n = 0;
      while (config_ready !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        n++;
      end
      chk_b("speaker_mode", spk, speaker_mode);
      chk_b("recording_en", !spk, recording_en);
      chk_b("mixer_present", !spk & mix, mixer_present);
      chk_b("mixer_default_mute", !spk & mix, mixer_default_mute);
      chk_b("self_powered", spk & pwr, self_powered);
      chk_v("feature_units", spk ? 1 : (mix ? 3 : 2),
            topo_feature_units);
      chk_b("mixer_units", !spk & mix, topo_mixer_units);
      chk_v("vendor_id", ee ? {12'hA50, i[3:0]} : BUILTIN_VID,
            vendor_id);
      chk_v("product_id", ee ? {12'hB60, i[3:0]} :
            BUILTIN_PID_BASE | {spk, mix, pwr}, product_id);
      chk_b("serial_override", ee, serial_override);
      chk_b("serial_string_en", ee & mix, serial_string_en);
      chk_b("product_string_en", ee ? pwr : 1'b1,
            product_string_en);
      reg_read(ADDR_STATUS, d);
      chk_v("status", {3'h0, 1'b1, ee, spk & pwr, !spk & mix, spk},
            d);
      for (int o = 0; o < 10; o++) begin
        host.fetch(2'h0, o[3:0], d, v);
        chk_b("cfg valid", 1'b1, v);
        chk_v("cfg byte", exp_desc(2'h0, o[3:0], spk, pwr, mix),
              d);
      end
      mode_strap <= !spk;
      power_select_strap <= !pwr;
      mixer_select_strap <= !mix;
      repeat (6) @(posedge ref_clk);
      chk_b("held speaker_mode", spk, speaker_mode);
      host.fetch(2'h0, 4'h8, d, v);
      chk_v("held max power", pwr ? 8'h32 : 8'hFA, d);
    end
    for (int s = 1; s < 4; s++) begin
      for (int o = 0; o < 10; o++) begin
        host.fetch(s[1:0], o[3:0], d, v);
        chk_v("hid byte", exp_desc(s[1:0], o[3:0], 1'b0, 1'b0, 1'b0),
              d);
      end
    end
    for (int a = 4; a < 8; a++) reg_write(a[3:0], 8'h11 * a[7:0]);
    reg_write(ADDR_IR0, 8'hFF);
    chk_v("out report", 32'h77665544, hid_out_report);
    for (int a = 0; a < 10; a++) begin
      reg_read(a[3:0], d);
      chk_v("reg read", (a > 3 && a < 8) ? 8'h11 * a[7:0] :
            (a == 8 ? 8'h1D : 8'h00), d);
    end
    vol_up_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_b("pend on press", 1'b1, hid_report_pend);
    reg_read(ADDR_IR0, d);
    chk_v("ir0 vol up", 8'h01, d);
    vol_up_n <= 1'b1;
    vol_down_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reg_read(ADDR_IR0, d);
    chk_v("ir0 vol down", 8'h02, d);
    vol_down_n <= 1'b1;
    play_mute_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    play_mute_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_b("pend on mute", 1'b1, hid_report_pend);
    reg_read(ADDR_IR0, d);
    chk_v("ir0 mute", 8'h04, d);
    reg_read(ADDR_IR0, d);
    chk_v("ir0 cleared", 8'h00, d);
    chk_b("pend cleared", 1'b0, hid_report_pend);
    results();
  end
endmodule : test_usds_descriptor_select
